// File: core/csbi_pkg.sv
// constants for the chip select and bus interface block
package csbi_pkg;
   // -----------------------------------------------------------------
   // decode table sizes
   // -----------------------------------------------------------------
   localparam int CS_DEC_BITS  = 5;
   localparam int CS_DEC_ROWS  = 32;
   localparam int CS_INT_NUM   = 6;
   localparam int CS_MB_NUM    = 4;
   localparam int CS_OUT_NUM   = 10;
   // internal select indices
   localparam int SEL_FDC_CTRL = 0;
   localparam int SEL_FDC_STAT = 1;
   localparam int SEL_FDC_DATA = 2;
   localparam int SEL_FDC_OPS  = 3;
   localparam int SEL_RTC_ADDR = 4;
   localparam int SEL_RTC_DATA = 5;
   localparam int SEL_IDE_HI   = 6;
   // -----------------------------------------------------------------
   // data path sizes and reset values
   // -----------------------------------------------------------------
   localparam int DATA_W       = 8;
   localparam int RTC_DEPTH    = 128;
   localparam int RTC_AW       = 7;
   localparam logic [7:0] BYTE_RESET  = 8'h00;
   localparam logic [7:0] STAT_IDLE   = 8'h80;
   localparam logic [9:0] CS_NONE     = 10'h000;
   // default decode table: one select per combination, rest none
   localparam logic [9:0] CS_TABLE_DEFAULT [CS_DEC_ROWS] = '{
      10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020, 10'h040, 10'h080,
      10'h100, 10'h200, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
      10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
      10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 20000000;
   localparam int BUS_MAX_HZ   = 12000000;
   localparam int WAIT_STATES  = 0;
endpackage : csbi_pkg

// File: core/csbi_top.sv
// chip select decoder and host data path
`timescale 1ns/1ps
`default_nettype none
module csbi_top #(
   parameter logic [9:0] CS_TABLE [csbi_pkg::CS_DEC_ROWS] = csbi_pkg::CS_TABLE_DEFAULT
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       addr_latch_en,
   input  wire logic       decode_output_enable,
   input  wire logic       dma_ack_decode_inhibit,
   input  wire logic       decode_input_low,
   input  wire logic       decode_input_high,
   input  wire logic [2:0] region_address_bits,
   input  wire logic       io_read_n,
   input  wire logic       io_write_n,
   input  wire logic [7:0] at_data_in,
   output logic [7:0]      at_data_out,
   output logic            at_data_oe,
   input  wire logic       ide_bit7_in,
   output logic            ide_bit7_out,
   output logic            ide_bit7_oe,
   output logic [3:0]      mb_cs_n,
   output logic [7:0]      fdc_ctrl_reg,
   output logic [7:0]      fdc_ops_reg,
   output logic [7:0]      fdc_cmd_data,
   output logic            fdc_cmd_strobe,
   output logic [7:0]      fdc_stat_wr_reg,
   input  wire logic [7:0] fdc_status_in,
   input  wire logic [7:0] fdc_result_in
);
   // ---------------------------------------------------------------
   // select decode unit: input latches
   // ---------------------------------------------------------------
   logic       en_hold_reg;
   logic       dlo_hold_reg;
   logic       dhi_hold_reg;
   logic [2:0] ra_hold_reg;
   logic       ale_prev_reg;
   wire        ale_fall = ale_prev_reg & ~addr_latch_en;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ale_prev_reg <= 1'b1;
      end else begin
         ale_prev_reg <= addr_latch_en;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         en_hold_reg <= 1'b0;
      end else if (addr_latch_en) begin
         en_hold_reg <= decode_output_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dlo_hold_reg <= 1'b0;
      end else if (addr_latch_en) begin
         dlo_hold_reg <= decode_input_low;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dhi_hold_reg <= 1'b0;
      end else if (addr_latch_en) begin
         dhi_hold_reg <= decode_input_high;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ra_hold_reg <= 3'h0;
      end else if (addr_latch_en) begin
         ra_hold_reg <= region_address_bits;
      end
   end

   // ---------------------------------------------------------------
   // select decode unit: transparent path
   // ---------------------------------------------------------------
   // transparent while high, frozen after the falling edge
   wire       en_eff  = addr_latch_en ? decode_output_enable : en_hold_reg;
   wire       dlo_eff = addr_latch_en ? decode_input_low : dlo_hold_reg;
   wire       dhi_eff = addr_latch_en ? decode_input_high : dhi_hold_reg;
   wire [2:0] ra_eff  = addr_latch_en ? region_address_bits : ra_hold_reg;
   wire       unused_fall = ale_fall;

   // ---------------------------------------------------------------
   // select decode unit: table lookup
   // ---------------------------------------------------------------
   wire [4:0] dec_index = {dhi_eff, dlo_eff, ra_eff};
   wire [9:0] table_sel = CS_TABLE[dec_index];

   // ---------------------------------------------------------------
   // select decode unit: gating
   // ---------------------------------------------------------------
   wire       dec_ok    = en_eff & ~dma_ack_decode_inhibit;
   wire [9:0] cs_vec    = dec_ok ? table_sel : csbi_pkg::CS_NONE;
   wire [6:0] int_sel   = cs_vec[6:0];
   wire       any_int   = |int_sel;

   // ---------------------------------------------------------------
   // select decode unit: one name per internal cell
   // ---------------------------------------------------------------
   wire sel_ctrl  = int_sel[csbi_pkg::SEL_FDC_CTRL];
   wire sel_stat  = int_sel[csbi_pkg::SEL_FDC_STAT];
   wire sel_data  = int_sel[csbi_pkg::SEL_FDC_DATA];
   wire sel_ops   = int_sel[csbi_pkg::SEL_FDC_OPS];
   wire sel_index = int_sel[csbi_pkg::SEL_RTC_ADDR];
   wire sel_mem   = int_sel[csbi_pkg::SEL_RTC_DATA];
   wire sel_drive = int_sel[csbi_pkg::SEL_IDE_HI];

   // ---------------------------------------------------------------
   // board selects, active low, spare bit held inactive
   // ---------------------------------------------------------------
   wire [2:0] board_sel_n;
   genvar gb;
   generate
      for (gb = 0; gb < 3; gb = gb + 1) begin : g_board
         assign board_sel_n[gb] = ~cs_vec[7 + gb];
      end
   endgenerate
   assign mb_cs_n = {1'b1, board_sel_n};

   // ---------------------------------------------------------------
   // data path unit: strobes
   // ---------------------------------------------------------------
   wire rd_act = ~io_read_n & any_int;
   wire wr_act = ~io_write_n & any_int;
   logic wr_prev_reg;
   wire  wr_start = wr_act & ~wr_prev_reg;

   // ---------------------------------------------------------------
   // data path unit: write enables per cell
   // ---------------------------------------------------------------
   wire wr_ctrl  = wr_act & sel_ctrl;
   wire wr_stat  = wr_act & sel_stat;
   wire wr_data  = wr_act & sel_data;
   wire wr_ops   = wr_act & sel_ops;
   wire wr_index = wr_act & sel_index;
   wire cmd_go   = wr_start & sel_data;

   // ---------------------------------------------------------------
   // internal cells
   // ---------------------------------------------------------------
   logic [7:0] rtc_mem_reg [csbi_pkg::RTC_DEPTH];
   logic [6:0] rtc_index_reg;
   logic [7:0] cmd_data_reg;
   logic       cmd_strobe_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] ops_reg;
   logic [7:0] stat_wr_reg;

   // ---------------------------------------------------------------
   // write edge tracker and command strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_prev_reg    <= 1'b0;
         cmd_strobe_reg <= 1'b0;
      end else begin
         wr_prev_reg    <= wr_act;
         cmd_strobe_reg <= cmd_go;
      end
   end

   // ---------------------------------------------------------------
   // floppy control byte
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_reg <= csbi_pkg::BYTE_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= at_data_in;
      end
   end

   // ---------------------------------------------------------------
   // floppy operations byte
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ops_reg <= csbi_pkg::BYTE_RESET;
      end else if (wr_ops) begin
         ops_reg <= at_data_in;
      end
   end

   // ---------------------------------------------------------------
   // floppy status write byte
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stat_wr_reg <= csbi_pkg::BYTE_RESET;
      end else if (wr_stat) begin
         stat_wr_reg <= at_data_in;
      end
   end

   // ---------------------------------------------------------------
   // floppy command data byte
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd_data_reg <= csbi_pkg::BYTE_RESET;
      end else if (wr_data) begin
         cmd_data_reg <= at_data_in;
      end
   end

   // ---------------------------------------------------------------
   // clock memory index
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rtc_index_reg <= 7'h00;
      end else if (wr_index) begin
         rtc_index_reg <= at_data_in[6:0];
      end
   end

   // ---------------------------------------------------------------
   // clock memory, 128 byte locations
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < csbi_pkg::RTC_DEPTH; gi = gi + 1) begin : g_rtc
         always_ff @(posedge clk) begin
            if (!resetn) begin
               rtc_mem_reg[gi] <= csbi_pkg::BYTE_RESET;
            end else if (wr_act && int_sel[csbi_pkg::SEL_RTC_DATA] &&
                         rtc_index_reg == 7'(gi)) begin
               rtc_mem_reg[gi] <= at_data_in;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // read selection
   // ---------------------------------------------------------------
   wire [7:0] mem_byte   = rtc_mem_reg[rtc_index_reg];
   wire [7:0] index_byte = {1'b0, rtc_index_reg};

   // ---------------------------------------------------------------
   // drive port bit 7 toward the bus
   // ---------------------------------------------------------------
   wire [7:0] drive_byte = {ide_bit7_in, 7'h00};

   // ---------------------------------------------------------------
   // read byte choice
   // ---------------------------------------------------------------
   wire [7:0] rd_byte =
      sel_stat  ? fdc_status_in :
      sel_data  ? fdc_result_in :
      sel_ctrl  ? ctrl_reg :
      sel_ops   ? ops_reg :
      sel_index ? index_byte :
      sel_mem   ? mem_byte :
      sel_drive ? drive_byte :
      csbi_pkg::BYTE_RESET;

   // ---------------------------------------------------------------
   // data path unit: bus drive
   // ---------------------------------------------------------------
   // combinational path keeps zero wait states
   assign at_data_out = rd_act ? rd_byte : csbi_pkg::BYTE_RESET;
   assign at_data_oe  = rd_act;

   // ---------------------------------------------------------------
   // drive port bit 7
   // ---------------------------------------------------------------
   assign ide_bit7_out = at_data_in[7];
   assign ide_bit7_oe  = ~io_write_n & sel_drive;

   // ---------------------------------------------------------------
   // register outputs
   // ---------------------------------------------------------------
   assign fdc_ctrl_reg    = ctrl_reg;
   assign fdc_ops_reg     = ops_reg;
   assign fdc_stat_wr_reg = stat_wr_reg;
   assign fdc_cmd_data    = cmd_data_reg;
   assign fdc_cmd_strobe  = cmd_strobe_reg;
endmodule : csbi_top
`default_nettype wire

// File: verif/csbi_drive_model.sv
// drive-port model: bit 7 wire and controller status bytes
`timescale 1ns/1ps
`default_nettype none
module csbi_drive_model (
   input  wire logic       bit7_oe,
   input  wire logic       bit7_out,
   input  wire logic       level,
   output logic            bit7_in,
   output logic [7:0]      status,
   output logic [7:0]      result
);
   assign bit7_in = bit7_oe ? bit7_out : level;
   assign status  = 8'hC3;
   assign result  = 8'h96;
endmodule : csbi_drive_model
`default_nettype wire

// File: verif/csbi_assertions.sv
// concurrent checks on the block ports
`timescale 1ns/1ps
`default_nettype none
module csbi_checker (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       addr_latch_en,
   input wire logic       decode_output_enable,
   input wire logic       dma_ack_decode_inhibit,
   input wire logic       io_read_n,
   input wire logic       io_write_n,
   input wire logic [7:0] at_data_in,
   input wire logic [7:0] at_data_out,
   input wire logic       at_data_oe,
   input wire logic       ide_bit7_out,
   input wire logic       ide_bit7_oe,
   input wire logic [3:0] mb_cs_n,
   input wire logic [7:0] fdc_ctrl_reg,
   input wire logic       fdc_cmd_strobe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_oe_on_read: assert property (at_data_oe |-> !io_read_n) else $error("oe");
   a_idle_bus_zero: assert property (!at_data_oe |-> at_data_out == 8'h00)
      else $error("idle");
   a_inhibit_blocks: assert property (dma_ack_decode_inhibit
      |-> !at_data_oe && mb_cs_n == 4'hF) else $error("inhibit");
   a_enable_gates: assert property (!decode_output_enable && addr_latch_en
      |-> !at_data_oe && mb_cs_n[2:0] == 3'h7) else $error("enable");
   a_oe_needs_en: assert property (at_data_oe && addr_latch_en
      |-> decode_output_enable) else $error("oe en");
   a_ctrl_from_bus: assert property (!$stable(fdc_ctrl_reg) && $past(resetn)
      |-> $past(!io_write_n) && fdc_ctrl_reg == $past(at_data_in)) else $error("ctrl");
   a_strobe_pulse: assert property (fdc_cmd_strobe
      |-> $past(!io_write_n) ##1 !fdc_cmd_strobe) else $error("strobe");
   a_bit7_path: assert property (ide_bit7_oe
      |-> !io_write_n && ide_bit7_out == at_data_in[7]) else $error("bit7");
   c_read: cover property (at_data_oe);
   c_bit7: cover property (ide_bit7_oe);
   c_strobe: cover property (fdc_cmd_strobe);
endmodule : csbi_checker
bind csbi_top csbi_checker u_chk (.*);
`default_nettype wire

// File: verif/tb_csbi_top.sv
// self-checking bench for the block
`timescale 1ns/1ps
`default_nettype none
module tb_csbi_top;
   logic clk, resetn, addr_latch_en, decode_output_enable, dma_ack_decode_inhibit;
   logic decode_input_low, decode_input_high, io_read_n, io_write_n, ide_bit7_in;
   logic at_data_oe, ide_bit7_out, ide_bit7_oe, fdc_cmd_strobe, drive_level;
   logic [2:0] region_address_bits;
   logic [3:0] mb_cs_n;
   logic [4:0] idx_q;
   logic [7:0] at_data_in, at_data_out, fdc_ctrl_reg, fdc_ops_reg, fdc_cmd_data;
   logic [7:0] fdc_stat_wr_reg, fdc_status_in, fdc_result_in;
   int errors = 0;
   int checks_done = 0;
   assign {decode_input_high, decode_input_low, region_address_bits} = idx_q;
   csbi_top u_dut (.*);
   csbi_drive_model u_drv (.bit7_oe(ide_bit7_oe), .bit7_out(ide_bit7_out),
      .level(drive_level), .bit7_in(ide_bit7_in), .status(fdc_status_in),
      .result(fdc_result_in));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      @(posedge clk);
      idx_q <= idx;
      at_data_in <= d;
      io_write_n <= 1'b0;
      @(posedge clk);
      io_write_n <= 1'b1;
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] idx, input logic [7:0] d, input logic oe);
      @(posedge clk);
      idx_q <= idx;
      io_read_n <= 1'b0;
      #1 cmp({7'h0, at_data_oe}, {7'h0, oe});
      if (oe) cmp(at_data_out, d);
      @(posedge clk);
      io_read_n <= 1'b1;
   endtask : rd
   initial begin
      {addr_latch_en, decode_output_enable, io_read_n, io_write_n} = 4'hF;
      {resetn, dma_ack_decode_inhibit, drive_level, idx_q} = 8'h00;
      at_data_in = 8'h00;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      wr(5'd0, 8'hA5);
      wr(5'd3, 8'h3C);
      wr(5'd1, 8'h4B);
      wr(5'd2, 8'h5E);
      cmp({7'h0, fdc_cmd_strobe}, 8'h01);
      cmp(fdc_cmd_data, 8'h5E);
      cmp(fdc_ops_reg, 8'h3C);
      cmp(fdc_stat_wr_reg, 8'h4B);
      rd(5'd0, 8'hA5, 1'b1);
      rd(5'd1, 8'hC3, 1'b1);
      rd(5'd2, 8'h96, 1'b1);
      $display("register path done");
      wr(5'd4, 8'h7F);
      wr(5'd5, 8'h5A);
      wr(5'd4, 8'h00);
      wr(5'd5, 8'h11);
      wr(5'd4, 8'h7F);
      rd(5'd5, 8'h5A, 1'b1);
      $display("clock memory done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         idx_q <= 5'd7 + i[4:0];
         #1 cmp({4'h0, mb_cs_n}, 8'h0F ^ (8'h01 << i));
      end
      @(posedge clk);
      dma_ack_decode_inhibit <= 1'b1;
      #1 cmp({4'h0, mb_cs_n}, 8'h0F);
      wr(5'd0, 8'hFF);
      rd(5'd0, 8'h00, 1'b0);
      dma_ack_decode_inhibit <= 1'b0;
      decode_output_enable <= 1'b0;
      wr(5'd0, 8'hFF);
      rd(5'd0, 8'h00, 1'b0);
      decode_output_enable <= 1'b1;
      cmp(fdc_ctrl_reg, 8'hA5);
      $display("gating done");
      idx_q <= 5'd3;
      @(posedge clk);
      addr_latch_en <= 1'b0;
      wr(5'd0, 8'h77);
      cmp(fdc_ops_reg, 8'h77);
      cmp(fdc_ctrl_reg, 8'hA5);
      addr_latch_en <= 1'b1;
      wr(5'd0, 8'h12);
      cmp(fdc_ctrl_reg, 8'h12);
      $display("latch done");
      @(posedge clk);
      idx_q <= 5'd6;
      at_data_in <= 8'h80;
      io_write_n <= 1'b0;
      #1 cmp({6'h0, ide_bit7_oe, ide_bit7_in}, 8'h03);
      @(posedge clk);
      io_write_n <= 1'b1;
      #1 cmp({6'h0, ide_bit7_oe, ide_bit7_in}, 8'h00);
      drive_level <= 1'b1;
      rd(5'd6, 8'h80, 1'b1);
      $display("drive bit done");
      tally_and_finish;
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      tally_and_finish;
   end
endmodule : tb_csbi_top
`default_nettype wire
